// file: shared/itrseq_pkg.sv
package itrseq_pkg;
  // Timing.
  localparam int CLK_HZ       = 20_000_000;
  localparam int AUTO_MAX_S   = 2;
  localparam int AUTO_MAX_CYC = AUTO_MAX_S * CLK_HZ;
  localparam int NUM_INST     = 4;
  localparam int PAD_PINS     = 18;
  // Register byte offsets.
  localparam logic [7:0] ADDR_GCFG  = 8'h00;
  localparam logic [7:0] ADDR_CMD   = 8'h04;
  localparam logic [7:0] ADDR_QUERY = 8'h08;
  localparam logic [7:0] ADDR_CH_LO = 8'h10;
  localparam logic [7:0] ADDR_CH_HI = 8'h50;
  localparam logic [1:0] CH_MODE    = 2'h0;
  localparam logic [1:0] CH_WAIT    = 2'h1;
  localparam logic [1:0] CH_RUN     = 2'h2;
  localparam logic [1:0] CH_TMO     = 2'h3;
  // Global configuration fields.
  localparam int GCFG_ALLOC = 0;
  localparam int GCFG_SLEW  = 3;
  localparam int GCFG_DRIVE = 4;
  localparam int GCFG_PULL  = 6;
  localparam int GCFG_OE    = 8;
  localparam int GCFG_MASK0 = 10;
  localparam int GCFG_MASK1 = 14;
  localparam logic [31:0] GCFG_RST = 32'h0000_0001;
  // Command fields.
  localparam int CMD_SUB   = 0;
  localparam int CMD_INST  = 2;
  localparam int CMD_RUN   = 4;
  localparam int CMD_STOP  = 5;
  localparam int CMD_CFG   = 6;
  localparam int CMD_FAULT = 7;
  // Channel mode fields.
  localparam int MODE_TRIG = 0;
  localparam int MODE_GEN  = 2;
  localparam int MODE_CONT = 3;
  localparam int MODE_INF  = 4;
  localparam int MODE_SCAN = 5;
  localparam int MODE_SRC  = 6;
  localparam int MODE_REP  = 16;
  localparam logic [31:0] MODE_RST = 32'h0001_0000;
  localparam logic [2:0]  SRC_SELF = 3'h0;
  localparam logic [2:0]  SRC_PIN0 = 3'h1;
  localparam logic [2:0]  SRC_PIN1 = 3'h2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ITRSEQ_TM_AUTO   = 2'h0,
    ITRSEQ_TM_NORMAL = 2'h1,
    ITRSEQ_TM_NONE   = 2'h2
  } itrseq_tmode_t;

  typedef enum logic [3:0] {
    ST_READY  = 4'h0,
    ST_CONFIG = 4'h1,
    ST_ARMED  = 4'h3,
    ST_TRIGD  = 4'h2,
    ST_WAIT   = 4'h6,
    ST_RUN    = 4'h7,
    ST_DONE   = 4'h5,
    ST_AUTO   = 4'h4,
    ST_STOP   = 4'hC,
    ST_SCAN   = 4'hD,
    ST_BUSY   = 4'hE,
    ST_ERROR  = 4'hF
  } itrseq_state_t;

  // Sample-buffer depth in KiS, per allocation 1..6 and per instrument.
  localparam logic [0:5][0:3][5:0] BUF_KIS = '{
    '{6'h10, 6'h10, 6'h10, 6'h02},
    '{6'h20, 6'h04, 6'h04, 6'h02},
    '{6'h08, 6'h20, 6'h02, 6'h02},
    '{6'h10, 6'h04, 6'h20, 6'h02},
    '{6'h04, 6'h04, 6'h20, 6'h20},
    '{6'h08, 6'h10, 6'h02, 6'h02}
  };
endpackage

// file: shared/itrseq_ch_if.sv
`timescale 1ns/1ps
interface itrseq_ch_if;
  logic [31:0]              mode;
  logic [31:0]              waitc;
  logic [31:0]              runc;
  logic [31:0]              tmo;
  logic                     run;
  logic                     stop;
  logic                     cfg;
  logic                     fault;
  logic                     trig;
  itrseq_pkg::itrseq_state_t state;
  logic                     prefill;
  logic                     start;
  modport top  (output mode, waitc, runc, tmo, run, stop, cfg, fault, trig,
                input state, prefill, start);
  modport chan (input mode, waitc, runc, tmo, run, stop, cfg, fault, trig,
                output state, prefill, start);
endinterface

// file: hw/itrseq_chan.sv
`timescale 1ns/1ps
module itrseq_chan #(
  parameter int unsigned AUTO_MAX_CYCLES = itrseq_pkg::AUTO_MAX_CYC
) (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   ce,
  itrseq_ch_if.chan   bus
);
  typedef struct packed {
    itrseq_pkg::itrseq_state_t st;
    logic                      go;
    logic [31:0]               cnt;
    logic [15:0]               rep;
    logic                      start;
  } itrseq_chs_t;

  itrseq_chs_t s_ff;
  itrseq_chs_t nxt_s;
  logic [1:0]  tm;
  logic [32:0] floor_c;
  logic [31:0] tmo_c;
  logic [31:0] maxc;

  assign maxc = 32'(AUTO_MAX_CYCLES);
  assign tm = bus.mode[itrseq_pkg::MODE_TRIG +: 2];

  always_comb
  begin
    // Auto timeout is capped at the maximum and raised to wait plus run, or to the maximum if that sum is larger, when that sum exceeds it.
    floor_c = {1'b0, bus.waitc} + {1'b0, bus.runc};
    tmo_c = (bus.tmo > maxc) ? maxc : bus.tmo;
    if (floor_c > {1'b0, tmo_c})
    begin
      tmo_c = (floor_c > {1'b0, maxc}) ? maxc : floor_c[31:0];
    end
    nxt_s = s_ff;
    nxt_s.start = 1'b0;
    case (s_ff.st)
      itrseq_pkg::ST_READY, itrseq_pkg::ST_DONE, itrseq_pkg::ST_STOP,
      itrseq_pkg::ST_CONFIG:
      begin
        if (bus.run || bus.cfg)
        begin
          nxt_s.st = itrseq_pkg::ST_CONFIG;
          nxt_s.go = bus.run;
        end
        else if (s_ff.st == itrseq_pkg::ST_CONFIG && s_ff.go)
        begin
          nxt_s.st = itrseq_pkg::ST_ARMED;
          nxt_s.cnt = tmo_c;
          nxt_s.rep = (bus.mode[31:16] == 16'h0000) ? 16'h0001 : bus.mode[31:16];
        end
      end
      itrseq_pkg::ST_ARMED:
      begin
        if (tm == itrseq_pkg::ITRSEQ_TM_NONE)
        begin
          nxt_s.st = itrseq_pkg::ST_WAIT;
          nxt_s.cnt = bus.waitc;
          nxt_s.start = 1'b1;
        end
        else if (bus.trig)
        begin
          nxt_s.st = itrseq_pkg::ST_TRIGD;
          nxt_s.start = 1'b1;
        end
        else if (tm == itrseq_pkg::ITRSEQ_TM_AUTO && s_ff.cnt <= 32'h0000_0001)
        begin
          nxt_s.st = itrseq_pkg::ST_AUTO;
          nxt_s.start = 1'b1;
        end
        else if (tm == itrseq_pkg::ITRSEQ_TM_AUTO)
        begin
          nxt_s.cnt = s_ff.cnt - 32'h0000_0001;
        end
      end
      itrseq_pkg::ST_TRIGD, itrseq_pkg::ST_AUTO:
      begin
        nxt_s.st = itrseq_pkg::ST_WAIT;
        nxt_s.cnt = bus.waitc;
      end
      itrseq_pkg::ST_WAIT:
      begin
        if (s_ff.cnt <= 32'h0000_0001)
        begin
          nxt_s.st = bus.mode[itrseq_pkg::MODE_SCAN] ? itrseq_pkg::ST_SCAN
                                                      : itrseq_pkg::ST_RUN;
          nxt_s.cnt = bus.runc;
        end
        else
        begin
          nxt_s.cnt = s_ff.cnt - 32'h0000_0001;
        end
      end
      itrseq_pkg::ST_RUN:
      begin
        if (bus.mode[itrseq_pkg::MODE_CONT])
        begin
          nxt_s.st = itrseq_pkg::ST_RUN;
        end
        else if (s_ff.cnt > 32'h0000_0001)
        begin
          nxt_s.cnt = s_ff.cnt - 32'h0000_0001;
        end
        else if (bus.mode[itrseq_pkg::MODE_INF] || s_ff.rep > 16'h0001)
        begin
          if (!bus.mode[itrseq_pkg::MODE_INF])
          begin
            nxt_s.rep = s_ff.rep - 16'h0001;
          end
          if (tm == itrseq_pkg::ITRSEQ_TM_NONE)
          begin
            nxt_s.st = itrseq_pkg::ST_WAIT;
            nxt_s.cnt = bus.waitc;
            nxt_s.start = 1'b1;
          end
          else
          begin
            nxt_s.st = itrseq_pkg::ST_ARMED;
            nxt_s.cnt = tmo_c;
          end
        end
        else
        begin
          nxt_s.st = itrseq_pkg::ST_DONE;
        end
      end
      itrseq_pkg::ST_SCAN, itrseq_pkg::ST_ERROR:
      begin
        nxt_s.st = s_ff.st;
      end
      default:
      begin
        nxt_s.st = itrseq_pkg::ST_READY;
      end
    endcase
    if (bus.stop)
    begin
      nxt_s.st = itrseq_pkg::ST_STOP;
      nxt_s.go = 1'b0;
      nxt_s.start = 1'b0;
    end
    if (bus.fault)
    begin
      nxt_s.st = itrseq_pkg::ST_ERROR;
      nxt_s.go = 1'b0;
      nxt_s.start = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_ff <= '{st: itrseq_pkg::ST_READY, go: 1'b0, cnt: 32'h0000_0000,
                rep: 16'h0000, start: 1'b0};
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

  assign bus.state = s_ff.st;
  assign bus.prefill = (s_ff.st == itrseq_pkg::ST_CONFIG) ||
                       (s_ff.st == itrseq_pkg::ST_ARMED);
  assign bus.start = s_ff.start;
endmodule

// file: hw/itrseq_top.sv
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module itrseq_top #(
  parameter int unsigned AUTO_MAX_CYCLES = itrseq_pkg::AUTO_MAX_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output wire logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output wire logic        WREADY,
  output wire logic [1:0]  BRESP,
  output wire logic        BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output wire logic        ARREADY,
  output wire logic [31:0] RDATA,
  output wire logic [1:0]  RRESP,
  output wire logic        RVALID,
  input  wire logic        RREADY,
  input  wire logic [1:0]  TRIG_PIN_I,
  output wire logic [1:0]  TRIG_PIN_O,
  output wire logic [1:0]  TRIG_PIN_OE,
  input  wire logic [3:0]  SELF_TRIG,
  input  wire logic        HOST_LOST,
  output wire logic [3:0]  TRIG_BUS,
  output wire logic [15:0] INST_STATE,
  output wire logic [3:0]  PREFILL,
  output wire logic [23:0] BUF_KIS,
  output wire logic        PAD_SLEW,
  output wire logic [1:0]  PAD_DRIVE,
  output wire logic [1:0]  PAD_PULL
);
  typedef struct packed {
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [31:0]      gcfg;
    logic [3:0][31:0] mode;
    logic [3:0][31:0] waitc;
    logic [3:0][31:0] runc;
    logic [3:0][31:0] tmo;
    logic [3:0][1:0]  owner;
    logic [3:0]       query;
    logic [3:0]       run;
    logic [3:0]       stop;
    logic [3:0]       cfg;
    logic             fault;
    logic [1:0]       p1;
    logic [1:0]       p2;
    logic [1:0]       p3;
    logic [1:0]       tout;
  } itrseq_top_t;

  itrseq_top_t      s_ff;
  itrseq_top_t      nxt_s;
  logic [3:0][3:0]  st_w;
  logic [3:0]       pf_w;
  logic [3:0]       bus_w;
  logic [3:0]       trig_w;
  logic [1:0]       pin_edge;
  logic [5:0]       wdec;
  logic [5:0]       rdec;

  // Decodes a byte address into {hit, register id}; ids 4..19 are channel words.
  function automatic logic [5:0] dec(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a[1:0] == 2'h0)
    begin
      hit = (a < ADDR_CMD_END()) ||
            (a >= itrseq_pkg::ADDR_CH_LO && a < itrseq_pkg::ADDR_CH_HI);
    end
    return {hit, a[6:2]};
  endfunction

  function automatic logic [7:0] ADDR_CMD_END();
    return itrseq_pkg::ADDR_QUERY + 8'h04;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_word(input itrseq_top_t s,
                                          input logic [4:0]  id,
                                          input logic [3:0][3:0] st);
    logic [4:0] ci;
    logic [3:0] view;
    rd_word = 32'h0000_0000;
    ci = id - 5'h04;
    view = st[s.query[1:0]];
    if (s.query[3:2] != s.owner[s.query[1:0]])
    begin
      view = itrseq_pkg::ST_BUSY;
    end
    case (id)
      5'h00: rd_word = s.gcfg;
      5'h01: rd_word = 32'h0000_0000;
      5'h02: rd_word = {20'h0_0000, s.query, 2'h0, s.owner[s.query[1:0]], view};
      default:
      begin
        case (id[1:0])
          itrseq_pkg::CH_MODE: rd_word = s.mode[ci[3:2]];
          itrseq_pkg::CH_WAIT: rd_word = s.waitc[ci[3:2]];
          itrseq_pkg::CH_RUN:  rd_word = s.runc[ci[3:2]];
          default:             rd_word = s.tmo[ci[3:2]];
        endcase
      end
    endcase
  endfunction

  assign wdec = dec(s_ff.aw_addr);
  assign rdec = dec(ARADDR);
  assign pin_edge = s_ff.p2 & ~s_ff.p3;

  // Each instrument picks its own condition: its own SELF_TRIG input, a pin edge or any instrument's bus pulse.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      case (s_ff.mode[i][itrseq_pkg::MODE_SRC +: 3])
        itrseq_pkg::SRC_SELF: trig_w[i] = SELF_TRIG[i];
        itrseq_pkg::SRC_PIN0: trig_w[i] = pin_edge[0];
        itrseq_pkg::SRC_PIN1: trig_w[i] = pin_edge[1];
        3'h4, 3'h5, 3'h6, 3'h7:
          trig_w[i] = bus_w[s_ff.mode[i][itrseq_pkg::MODE_SRC +: 2]];
        default: trig_w[i] = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    logic [4:0]  ci;
    logic [1:0]  sub;
    logic [31:0] g;
    ci = wdec[4:0] - 5'h04;
    sub = s_ff.w_data[itrseq_pkg::CMD_SUB +: 2];
    g = merge(s_ff.gcfg, s_ff.w_data, s_ff.w_strb);
    nxt_s = s_ff;
    nxt_s.run = 4'h0;
    nxt_s.stop = 4'h0;
    nxt_s.cfg = 4'h0;
    nxt_s.fault = HOST_LOST;
    nxt_s.p1 = TRIG_PIN_I;
    nxt_s.p2 = s_ff.p1;
    nxt_s.p3 = s_ff.p2;
    // Pins drive the OR of the bus pulses each one selects.
    nxt_s.tout[0] = |(bus_w & s_ff.gcfg[itrseq_pkg::GCFG_MASK0 +: 4]);
    nxt_s.tout[1] = |(bus_w & s_ff.gcfg[itrseq_pkg::GCFG_MASK1 +: 4]);
    if (AWVALID && AWREADY)
    begin
      nxt_s.aw_got = 1'b1;
      nxt_s.aw_addr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      nxt_s.w_got = 1'b1;
      nxt_s.w_data = WDATA;
      nxt_s.w_strb = WSTRB;
    end
    if (s_ff.bvalid && BREADY)
    begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got)
    begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = wdec[5] ? itrseq_pkg::RESP_OKAY : itrseq_pkg::RESP_SLVERR;
      if (wdec[5])
      begin
        case (wdec[4:0])
          5'h00:
          begin
            nxt_s.gcfg = g;
            // Allocations outside 1..6 are not taken; the old one stays.
            if (g[2:0] == 3'h0 || g[2:0] == 3'h7)
            begin
              nxt_s.gcfg[2:0] = s_ff.gcfg[2:0];
            end
          end
          5'h01:
          begin
            if (s_ff.w_strb[0])
            begin
              nxt_s.run[sub] = s_ff.w_data[itrseq_pkg::CMD_RUN];
              nxt_s.stop[sub] = s_ff.w_data[itrseq_pkg::CMD_STOP];
              nxt_s.cfg[sub] = s_ff.w_data[itrseq_pkg::CMD_CFG];
              if (s_ff.w_data[itrseq_pkg::CMD_FAULT])
              begin
                nxt_s.fault = 1'b1;
              end
              if (s_ff.w_data[itrseq_pkg::CMD_RUN] || s_ff.w_data[itrseq_pkg::CMD_STOP])
              begin
                nxt_s.owner[sub] = s_ff.w_data[itrseq_pkg::CMD_INST +: 2];
              end
            end
          end
          5'h02:
          begin
            if (s_ff.w_strb[0])
            begin
              nxt_s.query = s_ff.w_data[3:0];
            end
          end
          default:
          begin
            case (wdec[1:0])
              itrseq_pkg::CH_MODE:
                nxt_s.mode[ci[3:2]] = merge(s_ff.mode[ci[3:2]], s_ff.w_data, s_ff.w_strb);
              itrseq_pkg::CH_WAIT:
                nxt_s.waitc[ci[3:2]] = merge(s_ff.waitc[ci[3:2]], s_ff.w_data, s_ff.w_strb);
              itrseq_pkg::CH_RUN:
                nxt_s.runc[ci[3:2]] = merge(s_ff.runc[ci[3:2]], s_ff.w_data, s_ff.w_strb);
              default:
                nxt_s.tmo[ci[3:2]] = merge(s_ff.tmo[ci[3:2]], s_ff.w_data, s_ff.w_strb);
            endcase
          end
        endcase
      end
    end
    if (s_ff.rvalid && RREADY)
    begin
      nxt_s.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rdec[5] ? rd_word(s_ff, rdec[4:0], st_w) : 32'h0000_0000;
      nxt_s.rresp = rdec[5] ? itrseq_pkg::RESP_OKAY : itrseq_pkg::RESP_SLVERR;
    end
  end

  // All state advances on the system clock, frozen while CE is low except that RESETN still loads the reset values.
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      s_ff <= '0;
      s_ff.gcfg <= itrseq_pkg::GCFG_RST;
      s_ff.mode <= {4{itrseq_pkg::MODE_RST}};
    end
    else if (CE)
    begin
      s_ff <= nxt_s;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ch
      itrseq_ch_if ch ();
      assign ch.mode = s_ff.mode[gi];
      assign ch.waitc = s_ff.waitc[gi];
      assign ch.runc = s_ff.runc[gi];
      assign ch.tmo = s_ff.tmo[gi];
      assign ch.run = s_ff.run[gi];
      assign ch.stop = s_ff.stop[gi];
      assign ch.cfg = s_ff.cfg[gi];
      assign ch.fault = s_ff.fault;
      assign ch.trig = trig_w[gi];
      assign st_w[gi] = ch.state;
      assign pf_w[gi] = ch.prefill;
      assign bus_w[gi] = ch.start;
      assign BUF_KIS[6*gi +: 6] = itrseq_pkg::BUF_KIS[s_ff.gcfg[2:0] - 3'h1][gi];
      itrseq_chan #(
        .AUTO_MAX_CYCLES (AUTO_MAX_CYCLES)
      ) u_chan (
        .clk    (CLOCK),
        .resetn (RESETN),
        .ce     (CE),
        .bus    (ch)
      );
    end
  endgenerate

  assign AWREADY = !s_ff.aw_got && !s_ff.bvalid;
  assign WREADY = !s_ff.w_got && !s_ff.bvalid;
  assign BVALID = s_ff.bvalid;
  assign BRESP = s_ff.bresp;
  assign ARREADY = !s_ff.rvalid;
  assign RVALID = s_ff.rvalid;
  assign RDATA = s_ff.rdata;
  assign RRESP = s_ff.rresp;
  assign TRIG_BUS = bus_w;
  assign INST_STATE = st_w;
  assign PREFILL = pf_w;
  assign TRIG_PIN_O = s_ff.tout;
  assign TRIG_PIN_OE = s_ff.gcfg[itrseq_pkg::GCFG_OE +: 2];
  assign PAD_SLEW = s_ff.gcfg[itrseq_pkg::GCFG_SLEW];
  assign PAD_DRIVE = s_ff.gcfg[itrseq_pkg::GCFG_DRIVE +: 2];
  assign PAD_PULL = s_ff.gcfg[itrseq_pkg::GCFG_PULL +: 2];
endmodule

// file: sim/itrseq_props.sv
`timescale 1ns/1ps
module itrseq_props (
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        AWREADY,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        HOST_LOST,
  input wire logic [3:0]  TRIG_BUS,
  input wire logic [15:0] INST_STATE,
  input wire logic [3:0]  PREFILL,
  input wire logic [1:0]  TRIG_PIN_O,
  input wire logic [1:0]  TRIG_PIN_OE,
  input wire logic [1:0]  PAD_DRIVE
);
  logic [3:0] pf;
  logic [3:0] go;
  // Per instrument: prefilling states, and states that may launch a bus pulse.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pf[i] = INST_STATE[i*4 +: 4] inside {4'h1, 4'h3};
      go[i] = INST_STATE[i*4 +: 4] inside {4'h2, 4'h4, 4'h6};
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  bvalid_hold_a: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped early");
  b_blocks_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted while response pending");
  read_turn_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  r_blocks_a: assert property (RVALID |-> !ARREADY)
    else $error("read accepted while data pending");
  fault_err_a: assert property (HOST_LOST |=> ##1 INST_STATE == 16'hFFFF)
    else $error("fault did not force error state");
  prefill_map_a: assert property (PREFILL == pf)
    else $error("prefill does not follow state");
  bus_pulse_a: assert property (|TRIG_BUS |=> (TRIG_BUS & $past(TRIG_BUS)) == 4'h0)
    else $error("bus trigger longer than one cycle");
  bus_start_a: assert property ((TRIG_BUS & ~go) == 4'h0)
    else $error("bus trigger outside a start state");
  pin_source_a: assert property (|TRIG_PIN_O |-> $past(|TRIG_BUS))
    else $error("pin output without bus trigger");
  reset_pads_a: assert property ($rose(RESETN) |-> TRIG_PIN_OE == 2'b00 && PAD_DRIVE == 2'b00)
    else $error("pad defaults wrong after reset");
endmodule
bind itrseq_top itrseq_props itrseq_props_inst (.CLOCK, .RESETN, .AWREADY, .WREADY, .BVALID,
  .BREADY, .ARVALID, .ARREADY, .RVALID, .HOST_LOST, .TRIG_BUS, .INST_STATE, .PREFILL,
  .TRIG_PIN_O, .TRIG_PIN_OE, .PAD_DRIVE);

// file: sim/itrseq_peer.sv
`timescale 1ns/1ps
module itrseq_peer (
  input  wire logic       clk,
  input  wire logic [1:0] pin_o,
  input  wire logic [1:0] pin_oe,
  output wire logic [1:0] pin_i
);
  logic [1:0] ext_ff = 2'b00;
  // The outside source only drives a pin that the device leaves as an input.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_ff);
  task automatic pulse(input int p, input int w);
    repeat (w) @(posedge clk) ext_ff[p] <= 1'b1;
    @(posedge clk) ext_ff[p] <= 1'b0;
  endtask
endmodule

// file: sim/itrseq_tb.sv
`timescale 1ns/1ps
module itrseq_tb;
  localparam logic [3:0] OP_RUN = 4'h1;
  localparam logic [3:0] OP_STOP = 4'h2;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        host_lost = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  self_trig = 4'h0;
  logic [31:0] last_data;
  logic [1:0]  last_resp;
  int          miscompares = 0;
  int          check_count = 0;
  int          cnt;
  wire         awready, wready, bvalid, arready, rvalid, pad_slew;
  wire [1:0]   bresp, rresp, pin_o, pin_oe, pin_i, pad_drive, pad_pull;
  wire [3:0]   trig_bus, prefill;
  wire [31:0]  rdata;
  wire [15:0]  inst_state;
  wire [23:0]  buf_kis;
  logic [23:0] kis [6] = '{24'h09_0410, 24'h08_4120, 24'h08_2808, 24'h0A_0110, 24'h82_0104,
                           24'h08_2408};
  itrseq_top #(.AUTO_MAX_CYCLES(64)) itrseq_top_inst (.CLOCK(clock), .RESETN(resetn), .CE(1'b1),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .TRIG_PIN_I(pin_i), .TRIG_PIN_O(pin_o),
    .TRIG_PIN_OE(pin_oe), .SELF_TRIG(self_trig), .HOST_LOST(host_lost), .TRIG_BUS(trig_bus),
    .INST_STATE(inst_state), .PREFILL(prefill), .BUF_KIS(buf_kis), .PAD_SLEW(pad_slew),
    .PAD_DRIVE(pad_drive), .PAD_PULL(pad_pull));
  itrseq_peer itrseq_peer_inst (.clk(clock), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
  initial forever #25 clock = ~clock;
  function automatic logic [3:0] st(input int i);
    return inst_state[i*4 +: 4];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic lim(input int n);
    if (n >= 3000)
    begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 3000)
    begin
      @(negedge clock);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      last_resp = bresp;
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    lim(n);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    logic ar, r;
    n = 0;
    r = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r && n < 3000)
    begin
      @(negedge clock);
      ar = arvalid & arready;
      r = rvalid;
      last_data = rdata;
      last_resp = rresp;
      @(posedge clock);
      if (ar) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    lim(n);
  endtask
  task automatic cmd(input logic [1:0] ins, input logic [1:0] inst, input logic [3:0] op);
    axw(8'h04, {24'h00_0000, op, inst, ins});
  endtask
  task automatic chcfg(input int i, input logic [31:0] m, input logic [31:0] wt,
                       input logic [31:0] rn, input logic [31:0] tm);
    axw(8'(16 + 16 * i), m);
    axw(8'(20 + 16 * i), wt);
    axw(8'(24 + 16 * i), rn);
    axw(8'(28 + 16 * i), tm);
  endtask
  task automatic wst(input int i, input logic [3:0] s);
    int n;
    n = 0;
    @(negedge clock);
    while (st(i) !== s && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    lim(n);
  endtask
  // Counts the cycles the instrument stays in its present state.
  task automatic dwell(input int i);
    logic [3:0] s;
    s = st(i);
    cnt = 0;
    while (st(i) === s && cnt < 3000)
    begin
      @(negedge clock);
      cnt++;
    end
    lim(cnt);
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    axr(8'h00);
    chk("gcfg", last_data, 32'h1);
    chk("pads", 32'({pin_oe, pad_slew, pad_drive, pad_pull}), 32'h0);
    axr(8'h10);
    chk("mode", last_data, 32'h0001_0000);
    for (int k = 0; k < 6; k++)
    begin
      axw(8'h00, 32'(k + 1 + (k % 2) * 8 + (k % 4) * 16 + ((k + 1) % 4) * 64));
      @(negedge clock);
      chk("kis", 32'(buf_kis), 32'(kis[k]));
      chk("pad", 32'({pad_slew, pad_drive, pad_pull}), 32'((k % 2) * 16 + (k % 4) * 4 + (k + 1) % 4));
    end
    axw(8'h00, 32'h0000_2101);
    chcfg(0, 32'h1, 32'h3, 32'h5, 32'h0);
    cmd(2'h0, 2'h0, OP_RUN);
    wst(0, 4'h1);
    chk("prefill", 32'(prefill[0]), 32'h1);
    wst(0, 4'h3);
    repeat (40) @(negedge clock);
    chk("normal", 32'(st(0)), 32'h3);
    @(posedge clock) self_trig <= 4'h1;
    wst(0, 4'h2);
    chk("trigbus", 32'(trig_bus), 32'h1);
    @(posedge clock) self_trig <= 4'h0;
    wst(0, 4'h6);
    dwell(0);
    chk("wait", 32'(cnt), 32'h3);
    dwell(0);
    chk("run", 32'(cnt), 32'h5);
    chk("done", 32'(st(0)), 32'h5);
    for (int k = 0; k < 2; k++)
    begin
      chcfg(2, 32'h0, 32'h1, 32'h1, k ? 32'hC8 : 32'h1E);
      cmd(2'h2, 2'h0, OP_RUN);
      wst(2, 4'h3);
      dwell(2);
      chk("auto", 32'(st(2)), 32'h4);
      chk("tmo", 32'(cnt > (k ? 62 : 28) && cnt < (k ? 66 : 32)), 32'h1);
    end
    chcfg(0, 32'h0000_01C1, 32'h1, 32'h1, 32'h0);
    cmd(2'h0, 2'h0, OP_RUN);
    wst(0, 4'h3);
    chcfg(3, 32'h0002_0002, 32'h2, 32'h2, 32'h0);
    cmd(2'h3, 2'h0, OP_RUN);
    wst(3, 4'h3);
    dwell(3);
    chk("none", 32'(cnt), 32'h1);
    wst(3, 4'h7);
    dwell(3);
    chk("rewait", 32'(st(3)), 32'h6);
    wst(3, 4'h5);
    chk("bustrig", 32'(st(0)), 32'h5);
    chk("pin_oe", 32'(pin_oe), 32'h1);
    chcfg(1, 32'h0002_0081, 32'h1, 32'h1, 32'h0);
    cmd(2'h1, 2'h0, OP_RUN);
    wst(1, 4'h3);
    itrseq_peer_inst.pulse(1, 2);
    wst(1, 4'h7);
    dwell(1);
    chk("rearm", 32'(st(1)), 32'h3);
    itrseq_peer_inst.pulse(1, 2);
    wst(1, 4'h5);
    chcfg(2, 32'h0000_000A, 32'h1, 32'h2, 32'h0);
    cmd(2'h2, 2'h0, OP_RUN);
    wst(2, 4'h7);
    repeat (30) @(negedge clock);
    chk("cont", 32'(st(2)), 32'h7);
    cmd(2'h2, 2'h0, OP_STOP);
    wst(2, 4'hC);
    cmd(2'h2, 2'h0, OP_RUN);
    wst(2, 4'h1);
    chcfg(3, 32'h0000_0022, 32'h1, 32'h1, 32'h0);
    cmd(2'h3, 2'h0, OP_RUN);
    wst(3, 4'hD);
    cmd(2'h0, 2'h2, OP_STOP);
    axw(8'h08, 32'h0);
    axr(8'h08);
    chk("busy", last_data & 32'h0000_0FFF, 32'h0000_002E);
    axw(8'h08, 32'h8);
    axr(8'h08);
    chk("owner", last_data & 32'h0000_0FFF, 32'h0000_082C);
    @(posedge clock) host_lost <= 1'b1;
    @(posedge clock) host_lost <= 1'b0;
    // The loss is registered once, then the channels enter the error state a cycle later.
    repeat (2) @(negedge clock);
    chk("fault", 32'(inst_state), 32'h0000_FFFF);
    cmd(2'h0, 2'h2, OP_STOP);
    wst(0, 4'hC);
    cmd(2'h0, 2'h2, 4'h8);
    @(negedge clock);
    chk("cmdfault", 32'(st(0)), 32'hF);
    axw(8'hF0, 32'h1);
    chk("wresp", 32'(last_resp), 32'h2);
    axr(8'hF0);
    chk("rresp", 32'(last_resp), 32'h2);
    chk("rdata", last_data, 32'h0);
    final_report();
  end
endmodule
